// ---- src/fso_pkg.sv ----
// shared constants and types for the filter setup and offset register bank
package fso_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_SETUPS = 8;
    // register indices; byte address is four times the index
    localparam logic [9:0] OFFSET_IDX_FIRST = 10'h029;
    localparam logic [9:0] OFFSET_IDX_LAST = 10'h030;
    localparam logic [9:0] FILTER_IDX_FIRST = 10'h040;
    // field positions of the per-setup filter register
    localparam int FTYPE_LSB = 12;
    localparam int FTYPE_MSB = 15;
    localparam int RATE_LSB = 0;
    localparam int RATE_MSB = 10;
    // reset values
    localparam logic [23:0] OFFSET_RST = 24'h800000;
    localparam logic [3:0] FTYPE_RST = 4'h2;
    localparam logic [10:0] RATE_RST = 11'h030;
    // filter type codes
    localparam logic [3:0] FT_SINC4 = 4'h0;
    localparam logic [3:0] FT_SINC4_AVG = 4'h1;
    localparam logic [3:0] FT_SINC3 = 4'h2;
    localparam logic [3:0] FT_SINC3_NOTCH = 4'h3;
    localparam logic [3:0] FT_SINC3_AVG = 4'h4;
    localparam logic [3:0] FT_POST1 = 4'h5;
    localparam logic [3:0] FT_POST4 = 4'h8;
    // fixed output rates of the post filters, in milli samples per second
    localparam logic [14:0] POST1_MSPS = 15'h65e7; // 26.087
    localparam logic [14:0] POST2_MSPS = 15'h5dc0; // 24.000
    localparam logic [14:0] POST3_MSPS = 15'h4b9b; // 19.355
    localparam logic [14:0] POST4_MSPS = 15'h3f52; // 16.210
    // divider giving a 50 Hz main notch for dual 50/60 Hz rejection
    localparam logic [10:0] RATE_DUAL_REJ = 11'h030;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [4:0] SEL_NONE = 5'h1f;

    typedef struct packed {
        logic sinc4;
        logic averaging;
        logic sixtyHzExtraNotch;
        logic [2:0] postFilter;
        logic reservedCode;
    } fso_filt_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } fso_wr_s;
endpackage : fso_pkg

// ---- src/fso_filter_offset_regs.sv ----
// per-setup filter settings and offset coefficients behind an AXI4-Lite slave
`timescale 1ns/100ps

module fso_filter_offset_regs (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [fso_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [fso_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] activeSetup,
    input wire logic calDone,
    input wire logic [23:0] calResult,
    output fso_pkg::fso_filt_s activeFilter,
    output logic [10:0] rateDividerValue,
    output logic [14:0] outputSampleRateMsps,
    output logic dualRejection,
    output logic [23:0] activeOffset
);
    import fso_pkg::*;

    logic [23:0] offsetQ [NUM_SETUPS];
    logic [3:0] filterTypeQ [NUM_SETUPS];
    logic [10:0] rateDividerWordQ [NUM_SETUPS];
    fso_wr_s wrQ;
    logic awHeldQ;
    logic wHeldQ;
    logic bvalidQ;
    logic [1:0] brespQ;
    logic rvalidQ;
    logic [31:0] rdataQ;
    logic [1:0] rrespQ;
    logic wrFire;
    logic [4:0] wrSel;
    logic [4:0] rdSel;
    logic [31:0] rdMux;
    fso_filt_s decoded;
    logic [10:0] effRate;
    logic [14:0] fixedRate;

    // address to register select: 0..7 offset, 8..15 filter, else none
    function automatic logic [4:0] regSel(input logic [ADDR_W-1:0] a);
        logic [9:0] idx;
        idx = a[ADDR_W-1:2];
        if (a[1:0] != 2'h0) begin
            return SEL_NONE;
        end else if (idx >= OFFSET_IDX_FIRST && idx <= OFFSET_IDX_LAST) begin
            return {2'h0, 3'(idx - OFFSET_IDX_FIRST)};
        end else if (idx >= FILTER_IDX_FIRST &&
                     idx < FILTER_IDX_FIRST + 10'(NUM_SETUPS)) begin
            return {2'h1, 3'(idx - FILTER_IDX_FIRST)};
        end
        return SEL_NONE;
    endfunction : regSel

    // byte-lane merge of a write into a stored word
    function automatic logic [23:0] laneMerge(input logic [23:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
        logic [23:0] res;
        res = old;
        for (int b = 0; b < 3; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction : laneMerge

    // write channel: address and data taken in either order
    assign s_axi_awready = !awHeldQ;
    assign s_axi_wready = !wHeldQ;
    assign wrFire = awHeldQ && wHeldQ && !bvalidQ;
    assign wrSel = regSel(wrQ.addr);
    assign s_axi_bvalid = bvalidQ;
    assign s_axi_bresp = brespQ;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
            wrQ <= '0;
        end else begin
            if (s_axi_awvalid && !awHeldQ) begin
                awHeldQ <= 1'b1;
                wrQ.addr <= s_axi_awaddr;
            end else if (wrFire) begin
                awHeldQ <= 1'b0;
            end
            if (s_axi_wvalid && !wHeldQ) begin
                wHeldQ <= 1'b1;
                wrQ.data <= s_axi_wdata;
                wrQ.strb <= s_axi_wstrb;
            end else if (wrFire) begin
                wHeldQ <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            bvalidQ <= 1'b0;
            brespQ <= RESP_OKAY;
        end else if (wrFire) begin
            bvalidQ <= 1'b1;
            brespQ <= (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalidQ <= 1'b0;
        end
    end

    // read channel
    assign s_axi_arready = !rvalidQ;
    assign s_axi_rvalid = rvalidQ;
    assign s_axi_rdata = rdataQ;
    assign s_axi_rresp = rrespQ;
    assign rdSel = regSel(s_axi_araddr);

    always_comb begin
        rdMux = 32'h0;
        if (rdSel[4:3] == 2'h0) begin
            rdMux = {8'h0, offsetQ[rdSel[2:0]]};
        end else if (rdSel[4:3] == 2'h1) begin
            rdMux[FTYPE_MSB:FTYPE_LSB] = filterTypeQ[rdSel[2:0]];
            rdMux[RATE_MSB:RATE_LSB] = rateDividerWordQ[rdSel[2:0]];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rvalidQ <= 1'b0;
            rdataQ <= 32'h0;
            rrespQ <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalidQ) begin
            rvalidQ <= 1'b1;
            rdataQ <= rdMux;
            rrespQ <= (rdSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalidQ <= 1'b0;
        end
    end

    // per-setup storage; calibration result beats a host write
    for (genvar g = 0; g < NUM_SETUPS; g++) begin : g_setup
        always_ff @(posedge core_clk) begin
            if (reset) begin
                offsetQ[g] <= OFFSET_RST;
            end else if (calDone && activeSetup == 3'(g)) begin
                offsetQ[g] <= calResult;
            end else if (wrFire && wrSel == {2'h0, 3'(g)}) begin
                offsetQ[g] <= laneMerge(offsetQ[g], wrQ.data, wrQ.strb);
            end
        end

        always_ff @(posedge core_clk) begin
            if (reset) begin
                filterTypeQ[g] <= FTYPE_RST;
                rateDividerWordQ[g] <= RATE_RST;
            end else if (wrFire && wrSel == {2'h1, 3'(g)}) begin
                if (wrQ.strb[1]) begin
                    filterTypeQ[g] <= wrQ.data[FTYPE_MSB:FTYPE_LSB];
                    rateDividerWordQ[g][10:8] <= wrQ.data[10:8];
                end
                if (wrQ.strb[0]) begin
                    rateDividerWordQ[g][7:0] <= wrQ.data[7:0];
                end
            end
        end
    end

    // filter type decode for the active setup
    always_comb begin
        decoded = '0;
        fixedRate = 15'h0;
        case (filterTypeQ[activeSetup])
            FT_SINC4: decoded.sinc4 = 1'b1;
            FT_SINC4_AVG: begin
                decoded.sinc4 = 1'b1;
                decoded.averaging = 1'b1;
            end
            FT_SINC3: decoded = '0;
            FT_SINC3_NOTCH: decoded.sixtyHzExtraNotch = 1'b1;
            FT_SINC3_AVG: decoded.averaging = 1'b1;
            4'h5: begin
                decoded.postFilter = 3'h1;
                fixedRate = POST1_MSPS;
            end
            4'h6: begin
                decoded.postFilter = 3'h2;
                fixedRate = POST2_MSPS;
            end
            4'h7: begin
                decoded.postFilter = 3'h3;
                fixedRate = POST3_MSPS;
            end
            FT_POST4: begin
                decoded.postFilter = 3'h4;
                fixedRate = POST4_MSPS;
            end
            default: decoded.reservedCode = 1'b1;
        endcase
    end

    // zero divider is treated as one
    assign effRate = (rateDividerWordQ[activeSetup] == 11'h0) ?
                     11'h001 : rateDividerWordQ[activeSetup];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            activeFilter <= '0;
            rateDividerValue <= RATE_RST;
            outputSampleRateMsps <= 15'h0;
            dualRejection <= 1'b0;
            activeOffset <= OFFSET_RST;
        end else begin
            activeFilter <= decoded;
            rateDividerValue <= effRate;
            outputSampleRateMsps <= fixedRate;
            dualRejection <= decoded.sixtyHzExtraNotch &&
                             effRate == RATE_DUAL_REJ;
            activeOffset <= offsetQ[activeSetup];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence wrTaken;
        wrFire;
    endsequence

    sequence respGiven;
        ##1 bvalidQ;
    endsequence

    offset_reset_a: assert property ($past(reset) |->
        offsetQ[0] == OFFSET_RST && offsetQ[7] == OFFSET_RST)
        else $error("offset not mid-scale after reset");
    ftype_reset_a: assert property ($past(reset) |->
        filterTypeQ[3] == FTYPE_RST)
        else $error("filter type reset wrong");
    rate_reset_a: assert property ($past(reset) |->
        rateDividerWordQ[5] == RATE_RST)
        else $error("rate divider reset wrong");
    rate_zero_a: assert property (
        rateDividerWordQ[activeSetup] == 11'h0 |=> rateDividerValue == 11'h001)
        else $error("zero divider not treated as one");
    cal_store_a: assert property (calDone |=>
        offsetQ[$past(activeSetup)] == $past(calResult))
        else $error("calibration result not stored");
    host_offset_a: assert property (
        wrTaken and (wrSel[4:3] == 2'h0) and (wrQ.strb == 4'hf) and !calDone
        |=> offsetQ[$past(wrSel[2:0])] == $past(wrQ.data[23:0]))
        else $error("host offset write lost");
    write_resp_a: assert property (wrTaken |-> respGiven)
        else $error("write response missing");
    sinc4_plain_a: assert property (
        filterTypeQ[activeSetup] == FT_SINC4 |=>
        activeFilter.sinc4 && !activeFilter.averaging &&
        activeFilter.postFilter == 3'h0)
        else $error("sinc4 decode wrong");
    avg_mode_a: assert property (
        filterTypeQ[activeSetup] == FT_SINC3_AVG |=>
        !activeFilter.sinc4 && activeFilter.averaging)
        else $error("sinc3 averaging decode wrong");
    sinc3_plain_a: assert property (
        filterTypeQ[activeSetup] == FT_SINC3 |=> activeFilter == '0)
        else $error("sinc3 decode wrong");
    notch_mode_a: assert property (
        filterTypeQ[activeSetup] == FT_SINC3_NOTCH |=>
        activeFilter.sixtyHzExtraNotch)
        else $error("extra notch not enabled");
    dual_rej_a: assert property (
        filterTypeQ[activeSetup] == FT_SINC3_NOTCH &&
        rateDividerWordQ[activeSetup] == RATE_DUAL_REJ |=> dualRejection)
        else $error("dual rejection not flagged");
    post_rate_a: assert property (
        filterTypeQ[activeSetup] == FT_POST1 |=>
        outputSampleRateMsps == POST1_MSPS && activeFilter.postFilter == 3'h1)
        else $error("post filter 1 rate wrong");
    post4_rate_a: assert property (
        filterTypeQ[activeSetup] == FT_POST4 |=>
        outputSampleRateMsps == POST4_MSPS)
        else $error("post filter 4 rate wrong");

    sequence readTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sinc4_avg_a: assert property (
        filterTypeQ[activeSetup] == FT_SINC4_AVG |=>
        activeFilter.sinc4 && activeFilter.averaging)
        else $error("sinc4 averaging decode wrong");
    post2_rate_a: assert property (
        filterTypeQ[activeSetup] == 4'h6 |=>
        outputSampleRateMsps == POST2_MSPS && activeFilter.postFilter == 3'h2)
        else $error("post filter 2 rate wrong");
    post3_rate_a: assert property (
        filterTypeQ[activeSetup] == 4'h7 |=>
        outputSampleRateMsps == POST3_MSPS && activeFilter.postFilter == 3'h3)
        else $error("post filter 3 rate wrong");
    read_resp_a: assert property (readTaken |=> rvalidQ)
        else $error("read data not returned");
    read_err_a: assert property (
        readTaken and (rdSel == SEL_NONE) |=>
        rrespQ == RESP_SLVERR && rdataQ == 32'h0)
        else $error("unmapped read not refused");
    write_err_a: assert property (
        wrTaken and (wrSel == SEL_NONE) |=> brespQ == RESP_SLVERR)
        else $error("unmapped write not refused");
    offset_hold_a: assert property (
        !calDone && !wrFire |=> $stable(offsetQ[2]))
        else $error("offset changed without a write");
endmodule : fso_filter_offset_regs

// ---- tb/fso_host_model.sv ----
// host-side AXI4-Lite master model for the register bank
`timescale 1ns/100ps
module fso_host_model (
    input logic core_clk,
    output logic [fso_pkg::ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [fso_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    output logic s_axi_rready
);
    import fso_pkg::*;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end
    // callers keep filter codes within 0000 to 1000
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
            end
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : fso_host_model

// ---- tb/filter_setup_offset_regs_tb.sv ----
// self-checking bench for the filter setup and offset register bank
`timescale 1ns/100ps
module filter_setup_offset_regs_tb;
    import fso_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, calDone, dualRejection;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, c;
    logic [1:0] bresp, rresp, resp;
    logic [2:0] activeSetup, su;
    logic [23:0] calResult, activeOffset;
    logic [10:0] rateDividerValue, dv;
    logic [14:0] outputSampleRateMsps;
    fso_filt_s activeFilter;
    logic [31:0] rng = 32'hd221;
    int n_mismatch = 0;
    int n_tests = 0;
    always #50 core_clk = ~core_clk;
    fso_filter_offset_regs DUT (.core_clk(core_clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .activeSetup(activeSetup), .calDone(calDone),
        .calResult(calResult), .activeFilter(activeFilter),
        .rateDividerValue(rateDividerValue),
        .outputSampleRateMsps(outputSampleRateMsps),
        .dualRejection(dualRejection), .activeOffset(activeOffset));
    fso_host_model HOST (.core_clk(core_clk), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [ADDR_W-1:0] oaddr(input logic [2:0] s);
        return ADDR_W'({OFFSET_IDX_FIRST + 10'(s), 2'b00});
    endfunction : oaddr
    function automatic logic [ADDR_W-1:0] faddr(input logic [2:0] s);
        return ADDR_W'({FILTER_IDX_FIRST + 10'(s), 2'b00});
    endfunction : faddr
    function automatic fso_filt_s efilt(input logic [3:0] k);
        fso_filt_s f;
        f = '0;
        f.sinc4 = (k == 4'h0) || (k == 4'h1);
        f.averaging = (k == 4'h1) || (k == 4'h4);
        f.sixtyHzExtraNotch = (k == 4'h3);
        if (k >= 4'h5 && k <= 4'h8) begin
            f.postFilter = 3'(k - 4'h4);
        end
        return f;
    endfunction : efilt
    function automatic logic [14:0] erate(input logic [3:0] k);
        case (k)
            4'h5: return POST1_MSPS;
            4'h6: return POST2_MSPS;
            4'h7: return POST3_MSPS;
            4'h8: return POST4_MSPS;
            default: return 15'h0;
        endcase
    endfunction : erate
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                         input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        HOST.rd(a, d, r);
        chk(32'(r), 32'(er), "read response");
        chk(d, e, "read data");
    endtask : rdchk
    task automatic end_sim;
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        end_sim();
    end
    initial begin
        activeSetup = 3'h0;
        calDone = 1'b0;
        calResult = 24'h0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        for (int s = 0; s < NUM_SETUPS; s++) begin
            rdchk(oaddr(3'(s)), 32'h800000, RESP_OKAY);
            rdchk(faddr(3'(s)), 32'h2030, RESP_OKAY);
        end
        chk(32'(activeOffset), 32'h800000, "offset at reset");
        for (int i = 0; i < 16; i++) begin
            rng = xs(rng);
            su = rng[2:0];
            HOST.wr(oaddr(su), rng, 4'hf, resp);
            chk(32'(resp), 32'(RESP_OKAY), "offset write resp");
            activeSetup <= su;
            rdchk(oaddr(su), {8'h0, rng[23:0]}, RESP_OKAY);
            chk(32'(activeOffset), 32'(rng[23:0]), "active offset");
        end
        // codes 0 to 8, then the extra notch at divider 48 and at 0
        for (int k = 0; k < 11; k++) begin
            rng = xs(rng);
            su = rng[2:0];
            c = (k < 9) ? 4'(k) : 4'h3;
            dv = (k == 9) ? 11'h030 : (k == 10) ? 11'h000 : rng[18:8];
            HOST.wr(faddr(su), {16'h0, c, 1'b0, dv}, 4'h3, resp);
            chk(32'(resp), 32'(RESP_OKAY), "filter write resp");
            activeSetup <= su;
            rdchk(faddr(su), {16'h0, c, 1'b0, dv}, RESP_OKAY);
            chk(32'(activeFilter), 32'(efilt(c)), "decode");
            chk(32'(outputSampleRateMsps), 32'(erate(c)), "rate");
            chk(32'(rateDividerValue), (dv == 0) ? 32'h1 : 32'(dv), "div");
            chk(32'(dualRejection), 32'(c == 4'h3 && dv == 11'h030), "rej");
        end
        for (int s = 0; s < NUM_SETUPS; s++) begin
            rng = xs(rng);
            @(posedge core_clk);
            activeSetup <= 3'(s);
            calResult <= rng[23:0];
            calDone <= 1'b1;
            @(posedge core_clk);
            calDone <= 1'b0;
            calResult <= ~rng[23:0];
            rdchk(oaddr(3'(s)), 32'(rng[23:0]), RESP_OKAY);
            chk(32'(activeOffset), 32'(rng[23:0]), "cal offset");
        end
        // byte strobes: only byte 0 changes, byte 3 has no storage
        HOST.wr(oaddr(3'h3), 32'h00123456, 4'hf, resp);
        HOST.wr(oaddr(3'h3), 32'hffffffa5, 4'h9, resp);
        rdchk(oaddr(3'h3), 32'h001234a5, RESP_OKAY);
        rdchk(12'h000, 32'h0, RESP_SLVERR);
        rdchk(12'h0c4, 32'h0, RESP_SLVERR);
        HOST.wr(12'h0a6, 32'h1234, 4'hf, resp);
        chk(32'(resp), 32'(RESP_SLVERR), "misaligned write");
        end_sim();
    end
endmodule : filter_setup_offset_regs_tb
